// ---- hdl/dli_defines.vh ----
// register map, field positions and constants of the line pin interface
`ifndef DLI_DEFINES_VH
`define DLI_DEFINES_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define DLI_OFS_CTRL        12'h000
`define DLI_OFS_POL         12'h004
`define DLI_OFS_STAT        12'h008
`define DLI_OFS_RXCNT       12'h00c

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define DLI_CTRL_MODE_LO    0
`define DLI_CTRL_MODE_HI    1
`define DLI_CTRL_MMODE      2
`define DLI_CTRL_CLEAR52    3
`define DLI_CTRL_LLB        4
`define DLI_CTRL_TXSEL_LO   8
`define DLI_CTRL_TXSEL_HI   10
`define DLI_CTRL_TXINV      11
`define DLI_CTRL_RXSEL      12
`define DLI_CTRL_RXINV      13
`define DLI_CTRL_MASK       32'h0000_3f1f
`define DLI_CTRL_RST        32'h0000_0000

// ----------------------------------------------------------------
// polarity register fields
// ----------------------------------------------------------------
`define DLI_POL_TPOS        0
`define DLI_POL_TNEG        1
`define DLI_POL_TLCLK       2
`define DLI_POL_RPOS        4
`define DLI_POL_RNEG        5
`define DLI_POL_ROHM        6
`define DLI_POL_RLCLK       7
`define DLI_POL_MASK        32'h0000_00f7
`define DLI_POL_RST         32'h0000_0000

// ----------------------------------------------------------------
// line modes
// ----------------------------------------------------------------
`define DLI_MODE_B3ZS       2'h0
`define DLI_MODE_HDB3       2'h1
`define DLI_MODE_AMI        2'h2
`define DLI_MODE_PLAIN      2'h3

// ----------------------------------------------------------------
// reference clock choices
// ----------------------------------------------------------------
`define DLI_TXREF_TLCLK     3'h0
`define DLI_TXREF_TCLKO     3'h1
`define DLI_TXREF_TCLKI     3'h2
`define DLI_TXREF_RLCLK     3'h3
`define DLI_TXREF_RCLKO     3'h4
`define DLI_RXREF_RLCLK     1'b0
`define DLI_RXREF_RCLKO     1'b1

// ----------------------------------------------------------------
// line rates in kHz and mask delay in reference periods
// ----------------------------------------------------------------
`define DLI_RATE_DS3_KHZ    44736
`define DLI_RATE_E3_KHZ     34368
`define DLI_RATE_CLEAR52_KHZ 52000
`define DLI_MASK_DELAY      3

`endif

// ---- hdl/dli_edge_det.v ----
// level tracker with optional two-stage synchroniser and edge pulses
`default_nettype none

module dli_edge_det #(
  parameter SYNC = 1
) (
  // clock and reset
  input  wire sys_clk,
  input  wire rst,
  // level in
  input  wire lvl_in,
  // tracked level and edges
  output wire lvl,
  output wire rise,
  output wire fall
);

  reg prev_q;

  generate
    if (SYNC != 0) begin : g_sync
      reg s1_q;
      reg s2_q;
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= lvl_in;
          s2_q <= s1_q;
        end
      end
      assign lvl = s2_q;
    end else begin : g_direct
      assign lvl = lvl_in;
    end
  endgenerate

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= lvl;
    end
  end

  assign rise = lvl & ~prev_q;
  assign fall = ~lvl & prev_q;

endmodule // dli_edge_det

`default_nettype wire

// ---- hdl/dli_line_if.v ----
// line-side bit-serial pin interface of one framer port
// Operation
// - bipolar mode without mask mode drives negative rail high for negative pulse.
// - transmit outputs update on rising edge of reference, falling when inverted.
// - transmit reference is line clock, or clock out, clock in, rx clocks.
// - each transmit line output has its own polarity inversion; the tx clock out has none.
// - mask output is mask input delayed three periods, rx mask in loopback.
// - high mask marks transmit bit invalid, low marks it valid.
// - receive line clock is rx reference and selectable for transmit too.
// - line rate 44.736, 34.368 or 52 MHz depending on port mode.
// - receive inputs sample on rising reference edge, falling when inverted.
// - receive reference is rx line clock, or rx clock output.
// - unipolar or mask mode carries plain rx data on positive rail.
// - each receive input and rx line clock have a polarity inversion.
// - unipolar or mask mode outputs plain tx data on positive rail.
// - high rx mask in mask mode marks overhead bits, which are ignored.
//
// Added by the designer: the register offsets and register access over APB.
`default_nettype none
`include "dli_defines.vh"

module dli_line_if (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // framer side, transmit
  input  wire        tx_pos_in,
  input  wire        tx_neg_in,
  input  wire        tx_data_in,
  output reg         tx_bit_req,
  // framer side, receive
  output reg         rx_pos_out,
  output reg         rx_neg_out,
  output reg         rx_data_out,
  output reg         rx_data_valid,
  // line pins, transmit
  input  wire        tx_clock_in,
  input  wire        tx_oh_mask_in,
  output reg         tx_line_clock_out,
  output reg         tx_clock_out,
  output reg         tx_pos_rail_out,
  output reg         tx_neg_rail_out,
  // line pins, receive
  input  wire        rx_line_clock_in,
  input  wire        rx_pos_rail_in,
  input  wire        rx_neg_rail_in,
  output reg         rx_clock_out
);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  reg  [31:0] ctrl_q;
  reg  [31:0] pol_q;
  reg  [15:0] rx_cnt_q;

  wire [1:0] line_mode        = ctrl_q[`DLI_CTRL_MODE_HI:`DLI_CTRL_MODE_LO];
  wire       overhead_mask_mode = ctrl_q[`DLI_CTRL_MMODE];
  wire       clear_channel_52_mode = ctrl_q[`DLI_CTRL_CLEAR52];
  wire       loopback         = ctrl_q[`DLI_CTRL_LLB];
  wire [2:0] tx_ref_sel       = ctrl_q[`DLI_CTRL_TXSEL_HI:`DLI_CTRL_TXSEL_LO];
  wire       tx_ref_inv       = ctrl_q[`DLI_CTRL_TXINV];
  wire       rx_ref_sel       = ctrl_q[`DLI_CTRL_RXSEL];
  wire       rx_ref_inv       = ctrl_q[`DLI_CTRL_RXINV];
  wire       single_rail_unipolar_mode = (line_mode == `DLI_MODE_PLAIN);
  // plain data on the positive rail
  wire       plain_data       = single_rail_unipolar_mode | overhead_mask_mode;

  // ----------------------------------------------------------------
  // apb slave, zero wait state, answer in first access cycle
  // ----------------------------------------------------------------
  wire setup_ph = psel & ~penable;
  wire done_ph  = psel & penable & pready;
  wire hit_ctrl = (paddr == `DLI_OFS_CTRL);
  wire hit_pol  = (paddr == `DLI_OFS_POL);
  wire hit_stat = (paddr == `DLI_OFS_STAT);
  wire hit_cnt  = (paddr == `DLI_OFS_RXCNT);
  wire hit_any  = hit_ctrl | hit_pol | hit_stat | hit_cnt;
  wire [31:0] stat_w;
  reg  [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux = ctrl_q;
    end else if (hit_pol) begin
      rd_mux = pol_q;
    end else if (hit_stat) begin
      rd_mux = stat_w;
    end else if (hit_cnt) begin
      rd_mux = {16'h0000, rx_cnt_q};
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (setup_ph) begin
      pready  <= 1'b1;
      pslverr <= ~hit_any;
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
    end else if (done_ph) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // software-held port configuration
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `DLI_CTRL_RST;
      pol_q  <= `DLI_POL_RST;
    end else if (done_ph & pwrite) begin
      if (hit_ctrl) begin
        ctrl_q <= pwdata & `DLI_CTRL_MASK;
      end
      if (hit_pol) begin
        pol_q <= pwdata & `DLI_POL_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // clock pins: synchronise the two input pins and find edges
  // ----------------------------------------------------------------
  wire tci_lvl;
  wire tci_rise;
  wire tci_fall;
  wire rlc_lvl;
  wire rlc_rise;
  wire rlc_fall;
  wire tlc_rise;
  wire tlc_fall;
  wire tco_rise;
  wire tco_fall;
  wire rco_rise;
  wire rco_fall;

  dli_edge_det #(.SYNC(1)) u_tci (
    .sys_clk (sys_clk),
    .rst     (rst),
    .lvl_in  (tx_clock_in),
    .lvl     (tci_lvl),
    .rise    (tci_rise),
    .fall    (tci_fall)
  );

  dli_edge_det #(.SYNC(1)) u_rlc (
    .sys_clk (sys_clk),
    .rst     (rst),
    .lvl_in  (rx_line_clock_in),
    .lvl     (rlc_lvl),
    .rise    (rlc_rise),
    .fall    (rlc_fall)
  );

  dli_edge_det #(.SYNC(0)) u_tlc (
    .sys_clk (sys_clk),
    .rst     (rst),
    .lvl_in  (tx_line_clock_out),
    .lvl     (),
    .rise    (tlc_rise),
    .fall    (tlc_fall)
  );

  dli_edge_det #(.SYNC(0)) u_tco (
    .sys_clk (sys_clk),
    .rst     (rst),
    .lvl_in  (tx_clock_out),
    .lvl     (),
    .rise    (tco_rise),
    .fall    (tco_fall)
  );

  dli_edge_det #(.SYNC(0)) u_rco (
    .sys_clk (sys_clk),
    .rst     (rst),
    .lvl_in  (rx_clock_out),
    .lvl     (),
    .rise    (rco_rise),
    .fall    (rco_fall)
  );

  // rx line clock after its own polarity inversion
  wire rlc_pos = pol_q[`DLI_POL_RLCLK] ? rlc_fall : rlc_rise;
  wire rlc_neg = pol_q[`DLI_POL_RLCLK] ? rlc_rise : rlc_fall;

  // clock outputs follow the clock pins
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_line_clock_out <= 1'b0;
      tx_clock_out      <= 1'b0;
      rx_clock_out      <= 1'b0;
    end else begin
      tx_line_clock_out <= tci_lvl ^ pol_q[`DLI_POL_TLCLK];
      tx_clock_out      <= tci_lvl;
      rx_clock_out      <= rlc_lvl ^ pol_q[`DLI_POL_RLCLK];
    end
  end

  // ----------------------------------------------------------------
  // reference edge selection
  // ----------------------------------------------------------------
  reg tx_tick;
  reg rx_tick;

  always @* begin
    case (tx_ref_sel)
      `DLI_TXREF_TLCLK: tx_tick = tx_ref_inv ? tlc_fall : tlc_rise;
      `DLI_TXREF_TCLKO: tx_tick = tx_ref_inv ? tco_fall : tco_rise;
      `DLI_TXREF_TCLKI: tx_tick = tx_ref_inv ? tci_fall : tci_rise;
      `DLI_TXREF_RLCLK: tx_tick = tx_ref_inv ? rlc_neg : rlc_pos;
      `DLI_TXREF_RCLKO: tx_tick = tx_ref_inv ? rco_fall : rco_rise;
      default:          tx_tick = tx_ref_inv ? tlc_fall : tlc_rise;
    endcase
  end

  always @* begin
    case (rx_ref_sel)
      `DLI_RXREF_RLCLK: rx_tick = rx_ref_inv ? rlc_neg : rlc_pos;
      `DLI_RXREF_RCLKO: rx_tick = rx_ref_inv ? rco_fall : rco_rise;
      default:          rx_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // data pins: two flops to match the clock path
  // ----------------------------------------------------------------
  reg [3:0] pin_s1_q;
  reg [3:0] pin_s2_q;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end else begin
      pin_s1_q <= {tx_oh_mask_in, rx_neg_rail_in, rx_neg_rail_in, rx_pos_rail_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  // the negative rail pin doubles as the rx mask in mask mode
  wire rx_pos_pin  = pin_s2_q[0] ^ pol_q[`DLI_POL_RPOS];
  wire rx_neg_pin  = pin_s2_q[1] ^ pol_q[`DLI_POL_RNEG];
  wire rx_mask_pin = pin_s2_q[2] ^ pol_q[`DLI_POL_ROHM];
  wire tx_mask_pin = pin_s2_q[3];

  // ----------------------------------------------------------------
  // receive sampling
  // ----------------------------------------------------------------
  reg rx_mask_q;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_pos_out    <= 1'b0;
      rx_neg_out    <= 1'b0;
      rx_data_out   <= 1'b0;
      rx_data_valid <= 1'b0;
      rx_mask_q     <= 1'b0;
      rx_cnt_q      <= 16'h0000;
    end else begin
      rx_data_valid <= 1'b0;
      if (rx_tick) begin
        rx_cnt_q <= rx_cnt_q + 16'h0001;
        if (plain_data) begin
          rx_data_out <= rx_pos_pin;
          rx_pos_out  <= 1'b0;
          rx_neg_out  <= 1'b0;
        end else begin
          rx_pos_out  <= rx_pos_pin;
          rx_neg_out  <= rx_neg_pin;
          rx_data_out <= 1'b0;
        end
        rx_mask_q     <= overhead_mask_mode & rx_mask_pin;
        // overhead bits are dropped
        rx_data_valid <= ~(overhead_mask_mode & rx_mask_pin);
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit mask delay line and outputs
  // ----------------------------------------------------------------
  reg [`DLI_MASK_DELAY-1:0] mask_dly_q;
  wire mask_src = loopback ? rx_mask_pin : tx_mask_pin;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_dly_q <= {`DLI_MASK_DELAY{1'b0}};
    end else if (tx_tick) begin
      mask_dly_q <= {mask_dly_q[`DLI_MASK_DELAY-2:0], mask_src};
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_pos_rail_out <= 1'b0;
      tx_neg_rail_out <= 1'b0;
      tx_bit_req      <= 1'b0;
    end else begin
      tx_bit_req <= tx_tick;
      if (tx_tick) begin
        if (plain_data) begin
          tx_pos_rail_out <= tx_data_in ^ pol_q[`DLI_POL_TPOS];
        end else begin
          tx_pos_rail_out <= tx_pos_in ^ pol_q[`DLI_POL_TPOS];
        end
        if (overhead_mask_mode) begin
          // high marks the data bit as overwritable
          tx_neg_rail_out <= mask_dly_q[`DLI_MASK_DELAY-1] ^ pol_q[`DLI_POL_TNEG];
        end else if (single_rail_unipolar_mode) begin
          tx_neg_rail_out <= pol_q[`DLI_POL_TNEG];
        end else begin
          tx_neg_rail_out <= tx_neg_in ^ pol_q[`DLI_POL_TNEG];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // status: live pin levels and port state
  // ----------------------------------------------------------------
  assign stat_w = {20'h00000, clear_channel_52_mode, mask_dly_q, rx_mask_q,
                   plain_data, rlc_lvl, tci_lvl, rx_neg_pin, rx_pos_pin, tx_mask_pin,
                   1'b0};

endmodule // dli_line_if

`default_nettype wire

// ---- dv/dli_props.sv ----
// port assertions of the line pin interface
`default_nettype none
module dli_props (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // serial side
  input wire logic        tx_bit_req,
  input wire logic        rx_data_valid,
  input wire logic        tx_pos_rail_out,
  input wire logic        tx_neg_rail_out,
  // clock pins
  input wire logic        tx_clock_in,
  input wire logic        tx_clock_out,
  input wire logic        rx_line_clock_in,
  input wire logic        rx_clock_out
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  AST_APB_ANSWER: assert property (s_setup |=> s_done)
    else $error("apb setup not answered");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  AST_RAIL_ON_REQ: assert property ($changed({tx_pos_rail_out, tx_neg_rail_out}) |-> tx_bit_req)
    else $error("tx rail moved off tick");
  AST_REQ_PULSE: assert property (tx_bit_req |=> !tx_bit_req)
    else $error("bit request too long");
  AST_VALID_PULSE: assert property (rx_data_valid |=> !rx_data_valid)
    else $error("rx valid too long");
  AST_TXCLK_OUT: assert property ($rose(tx_clock_in) |-> ##[2:5] $rose(tx_clock_out))
    else $error("tx clock out late");
  AST_RXCLK_OUT: assert property ($changed(rx_line_clock_in) |-> ##[2:5] $changed(rx_clock_out))
    else $error("rx clock out late");
endmodule // dli_props
bind dli_line_if dli_props u_props (.sys_clk, .rst, .psel, .penable, .prdata, .pready, .pslverr,
  .tx_bit_req, .rx_data_valid, .tx_pos_rail_out, .tx_neg_rail_out, .tx_clock_in,
  .tx_clock_out, .rx_line_clock_in, .rx_clock_out);
`default_nettype wire

// ---- dv/dli_liu_model.sv ----
// behavioural line interface unit on the far side of the line pins
`default_nettype none
module dli_liu_model (
  // mode
  input  wire logic plain,
  // line pins
  output var  logic tx_clk,
  output var  logic rx_clk,
  output var  logic rx_pos,
  output var  logic rx_neg
);
  timeunit 1ns;
  timeprecision 1ps;
  integer     seed = 44;
  logic [1:0] r;
  // free-running line clocks, unrelated phase
  initial begin
    tx_clk = 1'b0;
    #7;
    forever #160 tx_clk = ~tx_clk;
  end
  initial begin
    rx_clk = 1'b0;
    #53;
    forever #160 rx_clk = ~rx_clk;
  end
  initial {rx_pos, rx_neg} = 2'h0;
  // data moves a quarter period after the rise, stable at both edges
  always @(posedge rx_clk) begin
    #80;
    r = 2'($random(seed));
    if (plain)
      {rx_pos, rx_neg} = r;
    else
      {rx_pos, rx_neg} = (r == 2'h3) ? 2'h0 : r;
  end
endmodule // dli_liu_model
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench of the line pin interface
`default_nettype none
`include "dli_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // signals
  // ----------
  logic        sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, pol = 32'h0, ctrl;
  logic        tx_pos_in = 1'b0, tx_neg_in = 1'b0, tx_data_in = 1'b0, tx_oh_mask_in = 1'b0;
  logic        tx_on = 1'b0, rx_on = 1'b0, plain = 1'b0, mmode = 1'b0, tinv = 1'b0;
  logic        rinv = 1'b0, ref_q = 1'b0;
  logic [2:0]  tsel = 3'h0, mh = 3'h0;
  logic [33:0] apbq[$];
  logic [1:0]  txq[$], rxq[$];
  integer      seed = 44, miscompares = 0, compares = 0, cnt = 0, ph;
  wire  [31:0] prdata;
  wire         pready, pslverr, tx_bit_req, rx_pos_out, rx_neg_out, rx_data_out;
  wire         rx_data_valid, tx_line_clock_out, tx_clock_out, tx_pos_rail_out;
  wire         tx_neg_rail_out, rx_clock_out, tx_clock_in, rx_line_clock_in;
  wire         rx_pos_rail_in, rx_neg_rail_in;
  wire         ref_pin = (tsel > 3'h2) ? rx_line_clock_in : tx_clock_in;

  always #20 sys_clk = ~sys_clk;

  dli_line_if dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tx_pos_in, .tx_neg_in, .tx_data_in, .tx_bit_req, .rx_pos_out,
    .rx_neg_out, .rx_data_out, .rx_data_valid, .tx_clock_in, .tx_oh_mask_in,
    .tx_line_clock_out, .tx_clock_out, .tx_pos_rail_out, .tx_neg_rail_out,
    .rx_line_clock_in, .rx_pos_rail_in, .rx_neg_rail_in, .rx_clock_out);
  dli_liu_model u_liu (.plain(plain), .tx_clk(tx_clock_in), .rx_clk(rx_line_clock_in),
    .rx_pos(rx_pos_rail_in), .rx_neg(rx_neg_rail_in));

  // ----------
  // tasks
  // ----------
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] x);
    integer n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    apbq.push_back({1'b0, x});
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      report_and_stop;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------
  // monitors and framer driver
  // ----------
  always @(posedge sys_clk)
    if (psel && penable && pready === 1'b1)
      check({1'b0, pslverr, pwrite ? 32'h0 : prdata}, apbq.pop_front());

  always @(posedge sys_clk) begin
    ref_q <= ref_pin;
    cnt <= (ref_pin != tinv && ref_q == tinv) ? 0 : cnt + 1;
  end

  always @(posedge sys_clk)
    if (tx_on && tx_bit_req === 1'b1) begin : tx_drive
      logic [3:0] r;
      r = 4'($random(seed));
      tx_pos_in <= r[0];
      tx_neg_in <= r[1];
      tx_data_in <= r[2];
      tx_oh_mask_in <= r[3] & mmode;
      txq.push_back({(plain ? r[2] : r[0]) ^ pol[0],
                     (mmode ? mh[2] : ~plain & r[1]) ^ pol[1]});
      mh <= {mh[1:0], r[3] & mmode};
    end

  always @(negedge sys_clk)
    if (tx_bit_req === 1'b1 && txq.size() > 0) begin
      check(34'({tx_pos_rail_out, tx_neg_rail_out}), 34'(txq.pop_front()));
      check(34'(cnt >= 2 && cnt <= 6), 34'h1);
    end

  // expected rx bits, noted at the selected line clock edge
  always @(rx_line_clock_in)
    if (rx_on && rx_line_clock_in != rinv && !(mmode && (rx_neg_rail_in ^ pol[6])))
      rxq.push_back(plain ? {1'b0, rx_pos_rail_in ^ pol[4]}
                          : {rx_pos_rail_in ^ pol[4], rx_neg_rail_in ^ pol[5]});

  always @(negedge sys_clk)
    if (rx_data_valid === 1'b1 && rxq.size() > 0)
      check(34'(plain ? {1'b0, rx_data_out} : {rx_pos_out, rx_neg_out}),
            34'(rxq.pop_front()));

  // ----------
  // main sequence
  // ----------
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, `DLI_OFS_CTRL, 32'h0, {1'b0, `DLI_CTRL_RST});
    apb(1'b0, `DLI_OFS_POL, 32'h0, {1'b0, `DLI_POL_RST});
    apb(1'b1, 12'h010, 32'hffff_ffff, 33'h1_0000_0000);
    apb(1'b0, 12'h010, 32'h0, 33'h1_0000_0000);
    for (ph = 0; ph < 10; ph++) begin
      tx_on <= 1'b0;
      rx_on <= 1'b0;
      @(posedge sys_clk);
      tx_oh_mask_in <= 1'b0;
      repeat (40) @(posedge sys_clk);
      // notes of the last phase belong to the old setup
      txq.delete();
      rxq.delete();
      mmode = ph > 4;
      plain = mmode || ph % 4 == 3;
      tsel = 3'(ph % 5);
      tinv = ph[0] ^ mmode;
      ctrl = ($random(seed) & 32'hffff_30e8) | {20'h0, tinv, tsel, 5'h0, mmode, 2'(ph % 4)};
      rinv = ctrl[13];
      pol = ($random(seed) & 32'hffff_ff08) | ($random(seed) & 32'h73);
      apb(1'b1, `DLI_OFS_CTRL, ctrl, 33'h0);
      apb(1'b0, `DLI_OFS_CTRL, 32'h0, {1'b0, ctrl & `DLI_CTRL_MASK});
      apb(1'b1, `DLI_OFS_POL, pol, 33'h0);
      apb(1'b0, `DLI_OFS_POL, 32'h0, {1'b0, pol & `DLI_POL_MASK});
      mh <= 3'h0;
      tx_on <= 1'b1;
      rx_on <= 1'b1;
      repeat (160) @(posedge sys_clk);
    end
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
